// [rtl/ch0_ctrl_regs.svh]
// How it works
// (R1) pwm prepared level moves only on frozen-to-pwm switch, compare result change or fast trigger hit (R6)
// (R2) compare mode write ignored when protect level is 11 and direction 00
// (R3) preload on: compare writes go to shadow, copied on update; off: direct
// (R4) software keeps preload on for pwm unless single pulse mode is active
// (R5) preload enable write ignored when protect level is 11 and direction 00
// (R6) fast enable in pwm: trigger edge acts as match, output goes active at once
// (R7) direction field writable only while channel enable is clear
// (R8) direction 00 compare output, 01 own filtered input, 10 channel 1 input
// (R9) direction 11 selects the internal trigger as capture source
// (R10) software picks the internal trigger source before using direction 11
// (R11) high prepared level is active; pin polarity applied by a polarity bit
// (R12) all control fields reset to zero: frozen compare output, no preload or fast
`ifndef CH0_CTRL_REGS_SVH
`define CH0_CTRL_REGS_SVH
`define A_CTRL     8'h00
`define A_CMP      8'h04
`define A_MISC     8'h08
`define A_STATUS   8'h0c
`define F_DIR      1:0
`define F_FAST     2
`define F_PRE      3
`define F_MODE     6:4
`define F_EN       0
`define F_POL      1
`define F_LOCK_LVL 3:2
`define F_PULSE    4
`define LOCK_LEVEL 2'h3
`define DIR_OUT    2'h0
`define DIR_OWN    2'h1
`define DIR_CROSS  2'h2
`define DIR_TRIG   2'h3
`define M_FROZEN   3'h0
`define M_SET      3'h1
`define M_CLR      3'h2
`define M_TOG      3'h3
`define M_LOW      3'h4
`define M_HIGH     3'h5
`define M_PWM0     3'h6
`define M_PWM1     3'h7
`define HTRANS_NSQ 2'h2
`endif

// [rtl/ch0_ctrl_pkg.sv]
`default_nettype none
package ch0_ctrl_pkg;
	typedef struct packed {
		logic [2:0] mode;
		logic       preload;
		logic       fast;
		logic [1:0] dir;
	} ctrl_s;
	typedef struct packed {
		logic       enable;
		logic       polarity;
		logic [1:0] write_protect_level;
		logic       single_pulse_mode;
	} misc_s;
endpackage
`default_nettype wire

// [rtl/cmp_shadow.sv]
`timescale 1ns/1ps
`default_nettype none
module cmp_shadow #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         resetn,
	// write side
	input  wire logic         wr,
	input  wire logic [W-1:0] wdata,
	input  wire logic         preload,
	input  wire logic         update,
	// values
	output var  logic [W-1:0] shadow_q,
	output var  logic [W-1:0] active_q
);
	// shadow capture and transfer to the active value
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			shadow_q <= '0;
			active_q <= '0;
		end else begin
			if (wr)
				shadow_q <= wdata;
			if (wr && !preload)
				active_q <= wdata; // R3
			else if (update && preload)
				active_q <= shadow_q; // R3
		end
	end
endmodule
`default_nettype wire

// [rtl/ch0_mode_ctrl.sv]
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ch0_ctrl_regs.svh"
module ch0_mode_ctrl #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         resetn,
	// ahb-lite slave
	input  wire logic         hsel,
	input  wire logic [7:0]   haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output var  logic [31:0]  hrdata,
	output var  logic         hreadyout,
	output var  logic         hresp,
	// timer core
	input  wire logic [W-1:0] counter,
	input  wire logic         count_down,
	input  wire logic         update_event,
	input  wire logic         trigger_edge,
	// capture sources
	input  wire logic         ch0_own_filtered_input,
	input  wire logic         ch1_cross_filtered_input,
	input  wire logic         internal_trigger_sel,
	// channel outputs
	output var  logic         ch0_out_prepare,
	output var  logic         ch0_output_pin,
	output var  logic         ch0_input_select,
	output var  logic         ch0_is_capture
);
	////////////////////////////////////////////////////////////////////////
	ch0_ctrl_pkg::ctrl_s ctrl_q;
	ch0_ctrl_pkg::misc_s misc_q;
	logic                wr_pend_q;
	logic [7:0]          addr_q;
	logic [W-1:0]        shadow_v;
	logic [W-1:0]        active_v;
	logic                cmp_hit_q;
	logic                ref_q;
	logic [2:0]          mode_prev_q;

	// address phase capture
	wire         take     = hsel && hready && (htrans == `HTRANS_NSQ);
	wire         wr_ctrl  = wr_pend_q && (addr_q == `A_CTRL);
	wire         wr_cmp   = wr_pend_q && (addr_q == `A_CMP);
	wire         wr_misc  = wr_pend_q && (addr_q == `A_MISC);
	wire         locked   = (misc_q.write_protect_level == `LOCK_LEVEL) &&
	                        (ctrl_q.dir == `DIR_OUT);
	wire [W-1:0] cmp_wdat = hwdata[W-1:0];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr_pend_q <= 1'b0;
			addr_q    <= 8'h00;
		end else begin
			wr_pend_q <= take && hwrite;
			addr_q    <= take ? haddr : addr_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control field writes with locks
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= '0; // R12
			misc_q <= '0;
		end else begin
			if (wr_ctrl) begin
				if (!locked)
					ctrl_q.mode <= hwdata[`F_MODE]; // R2
				if (!locked)
					ctrl_q.preload <= hwdata[`F_PRE]; // R5
				ctrl_q.fast <= hwdata[`F_FAST];
				if (!misc_q.enable)
					ctrl_q.dir <= hwdata[`F_DIR]; // R7
			end
			if (wr_misc) begin
				misc_q.enable              <= hwdata[`F_EN];
				misc_q.polarity            <= hwdata[`F_POL];
				misc_q.write_protect_level <= hwdata[`F_LOCK_LVL];
				misc_q.single_pulse_mode   <= hwdata[`F_PULSE];
			end
		end
	end

	cmp_shadow #(.W(W)) u_shadow (
		.clock    (clock),
		.resetn   (resetn),
		.wr       (wr_cmp),
		.wdata    (cmp_wdat),
		.preload  (ctrl_q.preload),
		.update   (update_event),
		.shadow_q (shadow_v),
		.active_q (active_v)
	);

	////////////////////////////////////////////////////////////////////////
	// prepared reference generation
	wire is_pwm   = (ctrl_q.mode == `M_PWM0) || (ctrl_q.mode == `M_PWM1);
	wire equal    = (counter == active_v);
	wire below    = count_down ? !(counter > active_v) : (counter < active_v);
	wire pwm_lvl  = (ctrl_q.mode == `M_PWM0) ? below : !below;
	wire from_frz = (mode_prev_q == `M_FROZEN);
	wire pwm_move = (pwm_lvl != cmp_hit_q) || from_frz; // R1
	wire fast_hit = ctrl_q.fast && is_pwm && trigger_edge; // R6
	logic ref_d;

	always_comb begin
		ref_d = ref_q;
		unique case (ctrl_q.mode)
			`M_FROZEN: ref_d = ref_q;
			`M_SET:    ref_d = equal ? 1'b1 : ref_q;
			`M_CLR:    ref_d = equal ? 1'b0 : ref_q;
			`M_TOG:    ref_d = equal ? !ref_q : ref_q;
			`M_LOW:    ref_d = 1'b0;
			`M_HIGH:   ref_d = 1'b1;
			`M_PWM0,
			`M_PWM1:   ref_d = fast_hit ? 1'b1 : (pwm_move ? pwm_lvl : ref_q); // R1 R6
		endcase
		if (ctrl_q.dir != `DIR_OUT)
			ref_d = ref_q;
	end

	// source selection for capture
	logic sel_d;
	always_comb begin
		unique case (ctrl_q.dir)
			`DIR_OUT:   sel_d = 1'b0; // R8
			`DIR_OWN:   sel_d = ch0_own_filtered_input; // R8
			`DIR_CROSS: sel_d = ch1_cross_filtered_input; // R8
			`DIR_TRIG:  sel_d = internal_trigger_sel; // R9
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ref_q            <= 1'b0;
			cmp_hit_q        <= 1'b0;
			mode_prev_q      <= `M_FROZEN;
			ch0_out_prepare  <= 1'b0;
			ch0_output_pin   <= 1'b0;
			ch0_input_select <= 1'b0;
			ch0_is_capture   <= 1'b0;
		end else begin
			ref_q            <= ref_d;
			cmp_hit_q        <= pwm_lvl;
			mode_prev_q      <= ctrl_q.mode;
			ch0_out_prepare  <= ref_d; // R11
			ch0_output_pin   <= misc_q.enable && (ref_d ^ misc_q.polarity); // R11
			ch0_input_select <= sel_d;
			ch0_is_capture   <= (ctrl_q.dir != `DIR_OUT);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data and response, zero wait
	wire [31:0] rd_ctrl = {25'h0, ctrl_q.mode, ctrl_q.preload, ctrl_q.fast, ctrl_q.dir};
	wire [31:0] rd_cmp  = {{(32-W){1'b0}}, active_v};
	wire [31:0] rd_misc = {27'h0, misc_q.single_pulse_mode, misc_q.write_protect_level,
	                       misc_q.polarity, misc_q.enable};
	wire [31:0] rd_stat = {29'h0, ch0_is_capture, ch0_input_select, ref_q};
	wire [31:0] rd_mux  = (haddr == `A_CTRL) ? rd_ctrl :
	                      (haddr == `A_CMP)  ? rd_cmp  :
	                      (haddr == `A_MISC) ? rd_misc :
	                      (haddr == `A_STATUS) ? rd_stat : 32'h0;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hrdata    <= (take && !hwrite) ? rd_mux : hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	sequence s_locked_wr;
		wr_ctrl && locked;
	endsequence
	chk_mode_lock: assert property (@(posedge clock) disable iff (!resetn) // R2 R5
		s_locked_wr |=> $stable(ctrl_q.mode) && $stable(ctrl_q.preload))
		else $error("mode or preload changed under lock");
	chk_dir_lock: assert property (@(posedge clock) disable iff (!resetn) // R7
		(wr_ctrl && misc_q.enable) |=> $stable(ctrl_q.dir))
		else $error("direction changed while enabled");
	chk_fast_hit: assert property (@(posedge clock) disable iff (!resetn) // R6
		(fast_hit && ctrl_q.dir == `DIR_OUT) |=> ch0_out_prepare)
		else $error("fast trigger did not drive output active");
	chk_direct_cmp: assert property (@(posedge clock) disable iff (!resetn) // R3
		(wr_cmp && !ctrl_q.preload) |=> active_v == $past(cmp_wdat))
		else $error("direct compare write not applied");
	chk_trig_src: assert property (@(posedge clock) disable iff (!resetn) // R9
		(ctrl_q.dir == `DIR_TRIG) |=> ch0_input_select == $past(internal_trigger_sel))
		else $error("trigger source not selected");
	chk_own_src: assert property (@(posedge clock) disable iff (!resetn) // R8
		(ctrl_q.dir == `DIR_OWN) |=> ch0_input_select == $past(ch0_own_filtered_input))
		else $error("own input not selected");
	chk_pwm_hold: assert property (@(posedge clock) disable iff (!resetn) // R1
		(is_pwm && ctrl_q.dir == `DIR_OUT && !fast_hit && !pwm_move) |=> $stable(ref_q))
		else $error("pwm reference moved without cause");
	chk_pin_pol: assert property (@(posedge clock) disable iff (!resetn) // R11
		misc_q.enable |=> ch0_output_pin == (ch0_out_prepare ^ $past(misc_q.polarity)))
		else $error("pin polarity wrong");
endmodule
`default_nettype wire

// [verification/timer_ch0_mode_compare_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ch0_ctrl_regs.svh"
module timer_ch0_mode_compare_ctrl_test;
	logic        clock = 1'h0, resetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic        upd = 1'h0, trig = 1'h0, cdn = 1'h0;
	logic [7:0]  haddr = 8'h0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata, rd;
	logic        hreadyout, hresp, ref_o, pin, isel, iscap;
	logic [2:0]  src = 3'h0;
	logic [15:0] cnt = 16'h0;
	int          num_errors = 0, total_checks = 0;

	always #50 clock = ~clock;

	ch0_mode_ctrl #(.W(16)) dut (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .counter(cnt),
		.count_down(cdn), .update_event(upd), .trigger_edge(trig),
		.ch0_own_filtered_input(src[0]), .ch1_cross_filtered_input(src[1]),
		.internal_trigger_sel(src[2]), .ch0_out_prepare(ref_o), .ch0_output_pin(pin),
		.ch0_input_select(isel), .ch0_is_capture(iscap));

	////////////////////////////////////////////////////////////////////////////////
	// bounded wait for the slave to answer
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (hreadyout !== 1'h1 && n < 50);
		if (n >= 50) num_errors++;
	endtask

	// one single ahb-lite transfer, read data left in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= w;
		htrans <= `HTRANS_NSQ;
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// expected capture source and pwm mode0 level
	function automatic logic exp_src(input logic [1:0] d, input logic [2:0] s);
		return (d == 2'h1) ? s[0] : (d == 2'h2) ? s[1] : s[2];
	endfunction

	function automatic logic exp_pwm(input logic dn, input logic [15:0] c, input logic [15:0] v);
		return dn ? (c <= v) : (c < v);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [1:0]  d;
		logic [15:0] cv;
		void'($urandom(32'h850d82de));
		repeat (6) @(posedge clock);
		resetn <= 1'h1;
		@(posedge clock);
		bus(1'h0, `A_CTRL, 32'h0); check("ctrl reset", 32'h0, rd);
		bus(1'h0, `A_MISC, 32'h0); check("misc reset", 32'h0, rd);
		bus(1'h1, 8'h10, 32'hffffffff);
		bus(1'h0, 8'h10, 32'h0); check("unmapped", 32'h0, rd);
		check("hresp", 32'h0, hresp);
		// every capture direction with random source levels
		for (int i = 1; i < 4; i++) begin
			d = 2'(i);
			bus(1'h1, `A_CTRL, {30'h0, d});
			src <= 3'($urandom);
			repeat (3) @(posedge clock);
			check("is_capture", 32'h1, iscap);
			check("input_select", exp_src(d, src), isel);
		end
		// direction frozen while enabled
		bus(1'h1, `A_MISC, 32'h1);
		bus(1'h1, `A_CTRL, 32'h0);
		bus(1'h0, `A_CTRL, 32'h0); check("dir locked", 32'h3, rd[1:0]);
		bus(1'h1, `A_MISC, 32'h0);
		bus(1'h1, `A_CTRL, 32'h0);
		bus(1'h0, `A_CTRL, 32'h0); check("dir open", 32'h0, rd[1:0]);
		check("compare out", 32'h0, iscap);
		// protection lock on mode and preload
		bus(1'h1, `A_MISC, 32'hc);
		bus(1'h1, `A_CTRL, 32'h78);
		bus(1'h0, `A_CTRL, 32'h0); check("locked ctrl", 32'h0, rd);
		bus(1'h1, `A_MISC, 32'h0);
		// preloaded and direct compare writes
		cv = 16'($urandom) | 16'h0100;
		bus(1'h1, `A_CTRL, 32'h08);
		bus(1'h1, `A_CMP, {16'h0, cv});
		bus(1'h0, `A_CMP, 32'h0); check("cmp held", 32'h0, rd);
		upd <= 1'h1;
		@(posedge clock);
		upd <= 1'h0;
		bus(1'h0, `A_CMP, 32'h0); check("cmp updated", {16'h0, cv}, rd);
		bus(1'h1, `A_CTRL, 32'h0);
		cv = {1'h0, 15'($urandom)} | 16'h0100;
		bus(1'h1, `A_CMP, {16'h0, cv});
		bus(1'h0, `A_CMP, 32'h0); check("cmp direct", {16'h0, cv}, rd);
		// pwm mode0 level against counter, corners at the compare value
		bus(1'h1, `A_MISC, 32'h1);
		bus(1'h1, `A_CTRL, 32'h68);
		for (int i = 0; i < 24; i++) begin
			cnt <= (i < 4) ? cv - 16'(i % 2) : 16'($urandom);
			cdn <= (i < 4) ? 1'(i / 2) : 1'($urandom);
			repeat (3) @(posedge clock);
			check("pwm level", exp_pwm(cdn, cnt, cv), ref_o);
			check("pin level", exp_pwm(cdn, cnt, cv), pin);
		end
		// inverted pin polarity on the last pwm point
		bus(1'h1, `A_MISC, 32'h3);
		repeat (2) @(posedge clock);
		check("pin inverted", {31'h0, !exp_pwm(cdn, cnt, cv)}, pin);
		bus(1'h1, `A_MISC, 32'h1);
		// fast trigger forces active level despite the comparison
		cdn <= 1'h0;
		cnt <= cv + 16'h1;
		bus(1'h1, `A_CTRL, 32'h6c);
		repeat (3) @(posedge clock);
		check("before trigger", 32'h0, ref_o);
		trig <= 1'h1;
		@(posedge clock);
		trig <= 1'h0;
		#1;
		check("fast trigger", 32'h1, ref_o);
		// forced and match-driven levels of the plain compare modes
		cnt <= cv;
		bus(1'h1, `A_CTRL, 32'h40);
		repeat (2) @(posedge clock);
		check("force low", 32'h0, ref_o);
		bus(1'h1, `A_CTRL, 32'h10);
		repeat (2) @(posedge clock);
		check("set on match", 32'h1, ref_o);
		bus(1'h1, `A_CTRL, 32'h20);
		repeat (2) @(posedge clock);
		check("clear on match", 32'h0, ref_o);
		bus(1'h1, `A_CTRL, 32'h50);
		repeat (2) @(posedge clock);
		check("force high", 32'h1, ref_o);
		bus(1'h0, `A_STATUS, 32'h0); check("status", 32'h1, rd);
		cnt <= cv + 16'h1;
		bus(1'h1, `A_CTRL, 32'h30);
		cnt <= cv;
		@(posedge clock);
		cnt <= cv + 16'h1;
		repeat (2) @(posedge clock);
		check("toggle on match", 32'h0, ref_o);
		wrap_up();
	end

	// watchdog well beyond the expected run of under two hundred cycles
	initial begin
		#500us;
		num_errors++;
		wrap_up();
	end
endmodule
`default_nettype wire
